// [core/cdac_pkg.sv]
/*
 * constants, types and helpers shared by the current dac update control block.
 * assumes an 8-bit register port and a 12-bit converter input latch.
 */
package cdac_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CONTROL = 8'hb9;   // dac_control
   localparam logic [7:0] ADDR_DATA_HIGH = 8'hba; // dac_data_high
   localparam logic [7:0] ADDR_DATA_LOW = 8'hbb;  // dac_data_low

   // ****************************************************************
   // control field layout and reset values
   // ****************************************************************
   localparam int EN_BIT = 7;                     // converter_enable
   localparam int CM_LSB = 4;                     // update_source_select, 3 bits
   localparam int RJST_BIT = 2;                   // right_justify_select
   localparam int FS_LSB = 0;                     // full_scale_select, 2 bits
   localparam logic [7:0] CTRL_RESET = 8'h73;     // enabled off, high-write, 2 mA
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hf7; // reserved bit 3 never stored
   localparam logic [7:0] DATA_RESET = 8'h00;     // holding bytes after reset
   localparam logic [11:0] CODE_RESET = 12'h000;  // converter latch after reset
   localparam int STROBE_FILL = 3;                // samples before edges are trusted

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int CODE_W = 12;                    // converter resolution
   localparam int CURRENT_W = 15;                 // code scaled by up to 8

   // update source encodings as held in the control register
   typedef enum logic [2:0] {
      SRC_TIMER0 = 3'h0,
      SRC_TIMER1 = 3'h1,
      SRC_TIMER2 = 3'h2,
      SRC_TIMER3 = 3'h3,
      SRC_RISE = 3'h4,
      SRC_FALL = 3'h5,
      SRC_ANY = 3'h6,
      SRC_HIGH_WRITE = 3'h7
   } cdac_source_type;

   // folds the two data bytes into the 12-bit word by the justification bit
   function automatic logic [11:0] cdac_map(input logic [7:0] hi, input logic [7:0] lo,
                                            input logic rj);
      if (rj) begin
         cdac_map = {hi[3:0], lo};
      end else begin
         cdac_map = {hi, lo[7:4]};
      end
   endfunction : cdac_map

endpackage : cdac_pkg

// [core/cdac_edge_if.sv]
/*
 * carrier for strobe edge pulses between the edge detector and the control core.
 * assumes both ends run on mclk.
 */
`timescale 1ns/1ps
interface cdac_edge_if;
   logic rise; // one-cycle pulse on a rising strobe edge
   logic fall; // one-cycle pulse on a falling strobe edge
   modport producer (output rise, output fall);
   modport consumer (input rise, input fall);
endinterface : cdac_edge_if

// [core/cdac_edge_detect.sv]
/*
 * synchronises the external convert strobe and reports its edges as pulses.
 * assumes the strobe is asynchronous to mclk and wider than two mclk periods.
 */
`timescale 1ns/1ps
module cdac_edge_detect
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic externalConvertStrobe,
   cdac_edge_if.producer edges
);
   import cdac_pkg::*;

   // ****************************************************************
   // synchroniser and edge history
   // ****************************************************************
   logic sync1_q, sync1_d;  // first stage, read only by the second
   logic sync2_q, sync2_d;  // second stage, safe to use
   logic prev_q, prev_d;    // last safe sample
   logic [1:0] fill_q, fill_d; // counts up until history is real

   // next values; no edge is reported until history holds real samples,
   // which avoids a false rise when the pin sits high out of reset
   always_comb begin
      sync1_d = externalConvertStrobe;
      sync2_d = sync1_q;
      prev_d = sync2_q;
      fill_d = fill_q;
      if (fill_q != 2'(STROBE_FILL)) begin
         fill_d = fill_q + 2'h1;
      end
   end

   // registers only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         fill_q <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
         fill_q <= fill_d;
      end
   end

   // edge pulses from the safe stage only
   assign edges.rise = (fill_q == 2'(STROBE_FILL)) && sync2_q && !prev_q;
   assign edges.fall = (fill_q == 2'(STROBE_FILL)) && !sync2_q && prev_q;

endmodule : cdac_edge_detect

// [core/cdac_update_control.sv]
/*
 * current dac update control: control and data registers, update event
 * selection, data justification and the converter input latch.
 * assumes timer overflow pulses come from mclk logic and the strobe from a pin.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module cdac_update_control
#(
   parameter int TIMER_COUNT = 4 // timer overflow inputs served
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData_q,
   input wire logic [TIMER_COUNT-1:0] timerOverflow,
   input wire logic externalConvertStrobe,
   output logic converterEnable_q,
   output logic [1:0] fullScaleSelect_q,
   output logic [cdac_pkg::CODE_W-1:0] dacCode_q,
   output logic [cdac_pkg::CURRENT_W-1:0] outputCurrent_q
);
   import cdac_pkg::*;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // the update source field encodes exactly four timers
   if (TIMER_COUNT != 4) begin : g_bad_timers
      $error("cdac_update_control serves exactly four timer overflows");
   end

   // ****************************************************************
   // strobe edge detection
   // ****************************************************************
   cdac_edge_if edgeBus (); // rise and fall pulses, mclk domain

   cdac_edge_detect u_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .externalConvertStrobe(externalConvertStrobe),
      .edges(edgeBus.producer)
   );

   // ****************************************************************
   // register state
   // ****************************************************************
   logic [7:0] control_q, control_d;   // dac_control, bit 3 always zero
   logic [7:0] dataHigh_q, dataHigh_d; // dac_data_high holding byte
   logic [7:0] dataLow_q, dataLow_d;   // dac_data_low holding byte
   logic [7:0] rdData_d;               // read answer for next cycle

   // decoded control fields and write strobes
   cdac_source_type source;  // update_source_select
   logic rightJustify;       // right_justify_select
   logic wrControl;          // write strobe aimed at control
   logic wrHigh;             // write strobe aimed at high byte
   logic wrLow;              // write strobe aimed at low byte

   assign source = cdac_source_type'(control_q[CM_LSB +: 3]);
   assign rightJustify = control_q[RJST_BIT];
   assign wrControl = regWr && (regAddr == ADDR_CONTROL);
   assign wrHigh = regWr && (regAddr == ADDR_DATA_HIGH);
   assign wrLow = regWr && (regAddr == ADDR_DATA_LOW);

   // register writes and the read answer
   always_comb begin
      control_d = control_q;
      dataHigh_d = dataHigh_q;
      dataLow_d = dataLow_q;
      rdData_d = 8'h00;
      // reserved bit is masked off so it never steers anything
      if (wrControl) begin
         control_d = regWrData & CTRL_WRITE_MASK;
      end
      // data bytes always land in the holding bytes; only an update event
      // moves them on, so a write moves the output only in high-write mode, where a high write is itself the event
      if (wrHigh) begin
         dataHigh_d = regWrData;
      end
      if (wrLow) begin
         dataLow_d = regWrData;
      end
      // read data stands for exactly one cycle, zero otherwise
      if (regRd) begin
         case (regAddr)
            ADDR_CONTROL: begin
               rdData_d = control_q & CTRL_WRITE_MASK;
            end
            ADDR_DATA_HIGH: begin
               rdData_d = dataHigh_q;
            end
            ADDR_DATA_LOW: begin
               rdData_d = dataLow_q;
            end
            default: begin
               rdData_d = 8'h00; // unmapped addresses read zero
            end
         endcase
      end
   end

   // register bank flops
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         control_q <= CTRL_RESET;
         dataHigh_q <= DATA_RESET;
         dataLow_q <= DATA_RESET;
         regRdData_q <= 8'h00;
      end else begin
         control_q <= control_d;
         dataHigh_q <= dataHigh_d;
         dataLow_q <= dataLow_d;
         regRdData_q <= rdData_d;
      end
   end

   // ****************************************************************
   // update event selection
   // ****************************************************************
   logic updateEvent;       // one-cycle: copy holding bytes to the latch
   logic [7:0] updateHigh;  // high byte used by the copy
   logic [CODE_W-1:0] mappedWord; // justified word to be latched

   // pick the event that the source field names
   always_comb begin
      updateEvent = 1'b0;
      updateHigh = dataHigh_q;
      case (source)
         // timer overflows are mclk pulses and need no synchroniser
         SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_TIMER3: begin
            updateEvent = timerOverflow[control_q[CM_LSB +: 2]];
         end
         SRC_RISE: begin
            updateEvent = edgeBus.rise;
         end
         SRC_FALL: begin
            updateEvent = edgeBus.fall;
         end
         SRC_ANY: begin
            updateEvent = edgeBus.rise || edgeBus.fall;
         end
         SRC_HIGH_WRITE: begin
            // the high byte being written counts at once; a low write waits
            updateEvent = wrHigh;
            updateHigh = regWrData;
         end
         default: begin
            updateEvent = 1'b0;
         end
      endcase
   end

   // both bytes are folded together in one step so the output never shows
   // a half-updated word
   assign mappedWord = cdac_map(updateHigh, dataLow_q, rightJustify);

   // ****************************************************************
   // converter input latch and output current
   // ****************************************************************
   logic [CODE_W-1:0] dacCode_d;        // next latch value
   logic [CURRENT_W-1:0] current_d;     // next output current
   logic enable_d;                      // next enable
   logic [1:0] fullScale_d;             // next full scale

   // latch and derived output; current is in units of 0.25 mA / 4096, so a
   // full-scale code shifts left by the full-scale field
   always_comb begin
      dacCode_d = dacCode_q;
      if (updateEvent) begin
         dacCode_d = mappedWord;
      end
      enable_d = control_q[EN_BIT];
      fullScale_d = control_q[FS_LSB +: 2];
      // a disabled converter sources no current at all
      if (converterEnable_q) begin
         current_d = CURRENT_W'(dacCode_q) << fullScaleSelect_q;
      end else begin
         current_d = '0;
      end
   end

   // output flops
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dacCode_q <= CODE_RESET;
         converterEnable_q <= CTRL_RESET[EN_BIT];
         fullScaleSelect_q <= CTRL_RESET[FS_LSB +: 2];
         outputCurrent_q <= '0;
      end else begin
         dacCode_q <= dacCode_d;
         converterEnable_q <= enable_d;
         fullScaleSelect_q <= fullScale_d;
         outputCurrent_q <= current_d;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic edgeMode; // a strobe-edge source is selected
   assign edgeMode = (source == SRC_RISE) || (source == SRC_FALL) || (source == SRC_ANY);

   property p_edge_hold;
      @(posedge mclk) disable iff (!rst_n)
      edgeMode && !edgeBus.rise && !edgeBus.fall |=> $stable(dacCode_q);
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("latch moved without strobe edge");

   property p_edge_select;
      @(posedge mclk) disable iff (!rst_n)
      (source == SRC_FALL) && edgeBus.rise |=> $stable(dacCode_q);
   endproperty
   a_edge_select: assert property (p_edge_select) else $error("falling mode took rise");

   property p_copy;
      @(posedge mclk) disable iff (!rst_n)
      updateEvent |=> dacCode_q == cdac_map($past(updateHigh), $past(dataLow_q),
                                            $past(rightJustify));
   endproperty
   a_copy: assert property (p_copy) else $error("update did not copy both bytes");

   property p_left_map;
      @(posedge mclk) disable iff (!rst_n)
      updateEvent && !rightJustify |=>
         dacCode_q == {$past(updateHigh), $past(dataLow_q[7:4])};
   endproperty
   a_left_map: assert property (p_left_map) else $error("left mapping wrong");

   property p_right_map;
      @(posedge mclk) disable iff (!rst_n)
      updateEvent && rightJustify |=>
         dacCode_q == {$past(updateHigh[3:0]), $past(dataLow_q)};
   endproperty
   a_right_map: assert property (p_right_map) else $error("right mapping wrong");

   property p_current;
      @(posedge mclk) disable iff (!rst_n)
      wrControl ##1 !wrControl ##1 converterEnable_q |=>
         outputCurrent_q == (CURRENT_W'($past(dacCode_q)) << $past(control_q[1:0]));
   endproperty
   a_current: assert property (p_current) else $error("current scale wrong");

   property p_reset_control;
      @(posedge mclk) disable iff (1'b0)
      !rst_n |=> control_q == CTRL_RESET && fullScaleSelect_q == 2'h3 && !converterEnable_q;
   endproperty
   a_reset_control: assert property (p_reset_control) else $error("bad reset control");

   property p_disabled;
      @(posedge mclk) disable iff (!rst_n)
      !converterEnable_q |=> outputCurrent_q == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled dac drives current");

   property p_timer;
      @(posedge mclk) disable iff (!rst_n)
      !control_q[CM_LSB + 2] && !timerOverflow[control_q[CM_LSB +: 2]] |=> $stable(dacCode_q);
   endproperty
   a_timer: assert property (p_timer) else $error("latch moved without timer overflow");

   property p_low_write;
      @(posedge mclk) disable iff (!rst_n)
      (source == SRC_HIGH_WRITE) && !wrHigh |=> $stable(dacCode_q);
   endproperty
   a_low_write: assert property (p_low_write) else $error("latch moved without high write");

   property p_reserved;
      @(posedge mclk) disable iff (!rst_n)
      regRd && (regAddr == ADDR_CONTROL) |=> regRdData_q[3] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit read as one");

   // read data must fall back to zero once its single cycle is over
   property p_read_idle;
      @(posedge mclk) disable iff (!rst_n)
      !regRd |=> regRdData_q == 8'h00;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data stood too long");

   // rising mode must ignore falling strobe edges
   property p_rise_select;
      @(posedge mclk) disable iff (!rst_n)
      (source == SRC_RISE) && edgeBus.fall |=> $stable(dacCode_q);
   endproperty
   a_rise_select: assert property (p_rise_select) else $error("rising mode took fall");

   // a control write reaches enable and full scale two edges later
   property p_control_follow;
      @(posedge mclk) disable iff (!rst_n)
      wrControl |=> ##1 converterEnable_q == $past(regWrData[EN_BIT], 2) &&
         fullScaleSelect_q == $past(regWrData[FS_LSB +: 2], 2);
   endproperty
   a_control_follow: assert property (p_control_follow) else $error("control lost");

endmodule : cdac_update_control

// [testbench/tb_cdac_update_control.sv]
/*
 * self-checking bench for the current dac update control block: register
 * access, update sources, justification, full-scale scaling and reset values.
 * assumes the design package and interface are compiled first.
 */
`timescale 1ns/1ps
module tb_cdac_update_control;
   import cdac_pkg::*;

   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   logic mclk = 1'b0; // 50 MHz system clock
   logic rst_n = 1'b0; // synchronous reset, active low
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData_q;
   logic [3:0] timerOverflow = 4'h0; // one-cycle overflow pulses
   logic externalConvertStrobe = 1'b0; // pin level, idle low
   logic converterEnable_q;
   logic [1:0] fullScaleSelect_q;
   logic [11:0] dacCode_q;
   logic [14:0] outputCurrent_q;
   int badCount = 0; // mismatches seen
   int testsRun = 0; // comparisons made
   logic [11:0] cur; // code the latch should hold
   logic [11:0] nxt; // code staged in the holding bytes
   logic [7:0] v; // last read data

   always #10 mclk = ~mclk;

   cdac_update_control #(.TIMER_COUNT(4)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q),
      .timerOverflow(timerOverflow), .externalConvertStrobe(externalConvertStrobe),
      .converterEnable_q(converterEnable_q), .fullScaleSelect_q(fullScaleSelect_q),
      .dacCode_q(dacCode_q), .outputCurrent_q(outputCurrent_q)
   );

   // ****************************************************************
   // bus tasks and comparison
   // ****************************************************************
   // a gap cycle between accesses keeps each strobe assigned once per step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData_q;
   endtask : rd

   task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one-cycle overflow pulse; the latch is looked at right after it
   task automatic pulse(input logic [3:0] t);
      @(posedge mclk);
      timerOverflow <= t;
      @(posedge mclk);
      timerOverflow <= 4'h0;
      #1;
   endtask : pulse

   // left-justified expectation, worked out here rather than borrowed
   function automatic logic [11:0] left(input logic [7:0] h, input logic [7:0] l);
      left = {h, l[7:4]};
   endfunction : left

   task automatic close_out;
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // guard against a hang anywhere in the sequence
   initial begin
      repeat (20000) @(posedge mclk);
      badCount++;
      close_out();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk("enable", 15'h0, {14'h0, converterEnable_q});
      chk("fullscale", 15'h3, {13'h0, fullScaleSelect_q});
      chk("code", 15'h0, {3'h0, dacCode_q});
      rd(ADDR_CONTROL, v);
      chk("control", 15'h73, {7'h0, v});
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, v);
      chk("control", 15'hf7, {7'h0, v});
      rd(8'hbc, v);
      chk("unmapped", 15'h0, {7'h0, v});
      // low byte alone must not move the latch in high-write mode
      wr(ADDR_DATA_LOW, 8'h5a);
      rd(ADDR_DATA_LOW, v);
      chk("low", 15'h5a, {7'h0, v});
      chk("code", 15'h0, {3'h0, dacCode_q});
      wr(ADDR_DATA_HIGH, 8'hc3);
      #1 chk("code", 15'h35a, {3'h0, dacCode_q});
      wr(ADDR_CONTROL, 8'hf3);
      wr(ADDR_DATA_HIGH, 8'hc3);
      #1 chk("code", 15'h0c35, {3'h0, dacCode_q});
      // every full-scale code scales the same latched word
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_CONTROL, {5'b11110, 1'b0, f[1:0]});
         repeat (2) @(posedge mclk);
         #1 chk("fullscale", 15'(f), {13'h0, fullScaleSelect_q});
         chk("current", 15'(12'hc35) << f, outputCurrent_q);
      end
      wr(ADDR_CONTROL, 8'h73);
      repeat (2) @(posedge mclk);
      #1 chk("enable", 15'h0, {14'h0, converterEnable_q});
      chk("current", 15'h0, outputCurrent_q);
      cur = 12'hc35;
      // timer sources: data held until the selected overflow only
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CONTROL, {1'b1, s[2:0], 4'h3});
         wr(ADDR_DATA_LOW, 8'h10 * s[7:0] + 8'h80);
         wr(ADDR_DATA_HIGH, 8'h21 + s[7:0]);
         nxt = left(8'h21 + s[7:0], 8'h10 * s[7:0] + 8'h80);
         #1 chk("code", 15'(cur), {3'h0, dacCode_q});
         pulse(4'h1 << ((s + 1) % 4));
         chk("code", 15'(cur), {3'h0, dacCode_q});
         pulse(4'h1 << s);
         cur = nxt;
         chk("code", 15'(cur), {3'h0, dacCode_q});
         @(posedge mclk);
         #1 chk("current", 15'(cur) << 3, outputCurrent_q);
      end
      // strobe sources: rise then fall, each with fresh held data
      for (int m = 4; m < 7; m++) begin
         wr(ADDR_CONTROL, {1'b1, m[2:0], 4'h3});
         wr(ADDR_DATA_LOW, 8'h40 + m[7:0]);
         wr(ADDR_DATA_HIGH, 8'h90 + m[7:0]);
         nxt = left(8'h90 + m[7:0], 8'h40 + m[7:0]);
         repeat (4) @(posedge mclk);
         #1 chk("code", 15'(cur), {3'h0, dacCode_q});
         @(posedge mclk);
         externalConvertStrobe <= 1'b1;
         repeat (6) @(posedge mclk);
         if (m != 5) cur = nxt;
         #1 chk("code", 15'(cur), {3'h0, dacCode_q});
         wr(ADDR_DATA_HIGH, 8'h0f - m[7:0]);
         nxt = left(8'h0f - m[7:0], 8'h40 + m[7:0]);
         externalConvertStrobe <= 1'b0;
         repeat (6) @(posedge mclk);
         if (m != 4) cur = nxt;
         #1 chk("code", 15'(cur), {3'h0, dacCode_q});
      end
      // a second reset in mid-run must restore the latch, full scale, enable, control and high byte reset values
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1 chk("code", 15'h0, {3'h0, dacCode_q});
      chk("fullscale", 15'h3, {13'h0, fullScaleSelect_q});
      chk("enable", 15'h0, {14'h0, converterEnable_q});
      rd(ADDR_CONTROL, v);
      chk("control", 15'h73, {7'h0, v});
      rd(ADDR_DATA_HIGH, v);
      chk("high", 15'h0, {7'h0, v});
      close_out();
   end

endmodule : tb_cdac_update_control
